// [crs_pkg.sv]
// Contract
// - bus runs at selected source divided by four; code divides clk_in by four even with pll selected
// - power-on/brown-out: clocks off, pin low 4096 cycles
// - bus clocks start only after stabilization timeout
// - wait mode stops cpu clocks, peripherals run
// - every reset asserts internal reset, picks vector
// - internal reset returns all modules to defaults
// - internal reset clears prescaler, pin reset does not
// - each source sets its own cause flag
// - pin low halts; flag after 67 or 4163 cycles
// - internal sources drive pin 32, hold 32 more
// - power-on: 4096 pin low, release 64 later
// - power-on enables clock gen, sets only its flag
// - watchdog overflow resets, sets watchdog flag
// - watchdog service clears counter and prescaler 12..4
// - watchdog disabled only by high test voltage cases
// - illegal or stop opcode sets flag and resets
// - opcode fetch outside memory resets, data fetch not
// - erased reset vector resets into monitor mode
// - brown-out persists nine cpu cycles, then long sequence
// - 13-bit prescaler overflow clocks the watchdog
// - prescaler runs freely after any reset sequence
// - reading cause register clears all flags
package crs_pkg;
    localparam int PRE_W          = 13;       // prescaler width
    localparam int WDT_W          = 6;        // watchdog counter width
    localparam int CNT_W          = 13;       // sequence and pin counters
    localparam int BUS_DIV        = 4;        // source cycles per bus cycle
    localparam int POR_CYCLES     = 4096;     // stabilization timeout
    localparam int DRIVE_CYCLES   = 32;       // pin driven low
    localparam int HOLD_CYCLES    = 32;       // internal reset beyond pin
    localparam int PIN_MIN        = 67;       // pin flag threshold
    localparam int PIN_MIN_POR    = 4163;     // threshold after power-on or brown-out
    localparam int BO_PERSIST     = 9;        // cpu cycles of low supply
    localparam int PRE_SVC_LO     = 4;        // lowest prescaler bit cleared
    localparam logic [15:0] VEC_USER = 16'hfffe; // reset vector
    localparam logic [15:0] VEC_MON  = 16'hfefe; // monitor vector
    localparam logic [7:0]  BLANK    = 8'hff;    // erased byte
    localparam int BIT_POR = 7;               // cause flag positions
    localparam int BIT_PIN = 6;
    localparam int BIT_WDT = 5;
    localparam int BIT_OPC = 4;
    localparam int BIT_ADR = 3;
    localparam int BIT_BLK = 2;
    localparam int BIT_BO  = 1;
    localparam logic [7:0] CAUSE_POR = 8'h80; // cause after power-on

    typedef enum logic [4:0] {
        CRS_RUN   = 5'h01,
        CRS_LONG  = 5'h02,
        CRS_DRIVE = 5'h04,
        CRS_HOLD  = 5'h08,
        CRS_EXT   = 5'h10
    } crs_phase_type;

    typedef struct packed {
        logic       opcode_valid;  // decoded instruction this cycle
        logic       bad_opcode;    // illegal instruction decoded
        logic       stop_opcode;   // stop instruction decoded
        logic       opcode_fetch;  // fetch is an opcode fetch
        logic       addr_mapped;   // fetch address is flash or ram
        logic       vector_fetch;  // reset vector byte read
        logic [7:0] vector_byte;   // byte read
    } crs_cpu_type;

    typedef struct packed {
        logic monitor;    // monitor mode
        logic break_st;   // break state
        logic hv_reset;   // test_high_voltage on reset pin
        logic hv_irq;     // test_high_voltage on interrupt pin
    } crs_test_type;

    typedef struct packed {
        logic bus_tick;   // one bus cycle strobe
        logic cpu_en;     // cpu clock enable
        logic periph_en;  // peripheral clock enable
        logic pll_sel;    // selected source is pll
    } crs_clk_type;

    typedef struct packed {
        crs_phase_type    phase;
        logic [CNT_W-1:0] seq;
        logic [PRE_W-1:0] pre;
        logic [1:0]       div;
        logic [WDT_W-1:0] wdt;
        logic [CNT_W-1:0] pin_cnt;
        logic [7:0]       cause;
        logic             por_src;
        logic             mon_force;
        logic             clk_gen_en;
    } crs_state_type;

    localparam crs_state_type STATE_RESET = '{
        phase: CRS_LONG, seq: '0, pre: '0, div: '0, wdt: '0,
        pin_cnt: '0, cause: CAUSE_POR, por_src: 1'b1,
        mon_force: 1'b0, clk_gen_en: 1'b1};
endpackage : crs_pkg

// [crs_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser, per-bit reset value
module crs_sync #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   INI = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         clk_en_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta;  // first stage, read only by q_out

    // plain double flop; metastability settles in stage one
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta  <= INI;
            q_out <= INI;
        end else if (clk_en_in) begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule : crs_sync

// [crs_persist.sv]
`timescale 1ns/1ps
// one pulse once a level has held for n consecutive ticks
module crs_persist #(
    parameter int N = 9
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic clk_en_in,
    input  wire logic level_in,
    input  wire logic tick_in,
    output logic      trip_out
);
    localparam int CW = $clog2(N + 1);
    logic [CW-1:0] cnt;  // consecutive ticks seen

    // saturates at n so one episode trips once
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt      <= '0;
            trip_out <= 1'b0;
        end else if (clk_en_in) begin
            trip_out <= 1'b0;
            if (!level_in) begin
                cnt <= '0;
            end else if (tick_in && cnt != CW'(N)) begin
                cnt      <= cnt + CW'(1);
                trip_out <= (cnt == CW'(N - 1));
            end
        end
    end
endmodule : crs_persist

// [crs_sequencer.sv]
`timescale 1ns/1ps
// reset and clock sequencer; clk_in is the oscillator reference
module crs_sequencer (
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic               clk_en_in,
    input  wire logic               power_up_pulse_in,
    input  wire logic               brownout_in,
    input  wire logic               watchdog_req_in,
    input  wire logic               wdt_service_in,
    input  wire logic               reset_pin_in,
    input  wire logic               pll_select_in,
    input  wire logic               wait_mode_in,
    input  wire logic               cause_read_in,
    input  wire crs_pkg::crs_cpu_type  cpu_in,
    input  wire crs_pkg::crs_test_type test_in,
    output logic                    reset_pin_out,
    output logic                    reset_pin_oe_out,
    output logic                    internal_reset_out,
    output logic                    clock_gen_en_out,
    output crs_pkg::crs_clk_type    clocks_out,
    output logic [15:0]             reset_vector_out,
    output logic                    monitor_force_out,
    output logic                    watchdog_on_out,
    output logic [7:0]              reset_cause_out,
    output logic [crs_pkg::PRE_W-1:0] prescaler_out
);
    crs_pkg::crs_state_type s;       // all registered state
    crs_pkg::crs_state_type next_s;  // value for next edge

    logic [1:0] sync_q;      // synchronised pin and watchdog request
    logic       pin_low;     // reset pin seen low
    logic       wdt_ext;     // outside watchdog request
    logic       bo_trip;     // brown-out persisted
    logic       run;         // normal operation
    logic       long_ph;     // stabilization phase
    logic       bus_tick;    // one cycle per bus cycle
    logic       wdt_dis;     // watchdog disabled by test voltage
    logic       wdt_tick;    // prescaler overflow
    logic       wdt_trip;    // watchdog reset request
    logic       opc_trip;    // illegal opcode
    logic       adr_trip;    // illegal opcode address
    logic       blk_trip;    // erased reset vector
    logic       int_trip;    // any short internal source
    logic       pin_set;     // pin flag sets this cycle
    logic [7:0] set_bits;    // flags raised this cycle
    logic [crs_pkg::CNT_W-1:0] pin_thr;  // pin flag threshold

    // pin idles high, request idles low
    crs_sync #(
        .W   (2),
        .INI (2'b01)
    ) u_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .clk_en_in (clk_en_in),
        .d_in      ({watchdog_req_in, reset_pin_in}),
        .q_out     (sync_q)
    );

    assign pin_low = !sync_q[0];
    assign wdt_ext = sync_q[1];

    // low supply must persist nine cpu cycles
    crs_persist #(
        .N (crs_pkg::BO_PERSIST)
    ) u_bo (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .clk_en_in (clk_en_in),
        .level_in  (brownout_in),
        .tick_in   (bus_tick),
        .trip_out  (bo_trip)
    );

    // phase decode from the one-hot register
    assign run     = (s.phase == crs_pkg::CRS_RUN);
    assign long_ph = (s.phase == crs_pkg::CRS_LONG);

    // bus strobe: source divided by four, none while stabilizing
    assign bus_tick = !long_ph && (s.div == 2'(crs_pkg::BUS_DIV - 1));

    // only the high test voltage paths can disable; noise cannot
    assign wdt_dis = (test_in.monitor && (test_in.hv_reset || test_in.hv_irq))
                   || (test_in.break_st && test_in.hv_reset);

    // prescaler wrap clocks the watchdog counter
    assign wdt_tick = (s.pre == '1);

    // reset requests are taken only in normal operation
    assign wdt_trip = run && !wdt_dis
                    && ((wdt_tick && s.wdt == '1) || wdt_ext);
    assign opc_trip = run && cpu_in.opcode_valid
                    && (cpu_in.bad_opcode || cpu_in.stop_opcode);
    assign adr_trip = run && cpu_in.opcode_fetch && !cpu_in.addr_mapped;
    assign blk_trip = run && cpu_in.vector_fetch
                    && (cpu_in.vector_byte == crs_pkg::BLANK);
    assign int_trip = wdt_trip || opc_trip || adr_trip || blk_trip;

    // pin flag threshold depends on the last long source
    assign pin_thr = s.por_src ? crs_pkg::CNT_W'(crs_pkg::PIN_MIN_POR)
                               : crs_pkg::CNT_W'(crs_pkg::PIN_MIN);
    assign pin_set = pin_low && (s.pin_cnt == pin_thr - crs_pkg::CNT_W'(1));

    // every source owns one flag
    always_comb begin
        set_bits = 8'h00;
        set_bits[crs_pkg::BIT_PIN] = pin_set;
        set_bits[crs_pkg::BIT_WDT] = wdt_trip;
        set_bits[crs_pkg::BIT_OPC] = opc_trip;
        set_bits[crs_pkg::BIT_ADR] = adr_trip;
        set_bits[crs_pkg::BIT_BLK] = blk_trip;
        set_bits[crs_pkg::BIT_BO]  = bo_trip && run;
    end

    // next-state logic for the whole block
    always_comb begin
        next_s = s;
        // bus divider idles during stabilization
        next_s.div = long_ph ? 2'h0 : s.div + 2'h1;
        // free-running prescaler; service clears the upper bits
        next_s.pre = s.pre + crs_pkg::PRE_W'(1);
        if (run && wdt_service_in) begin
            next_s.pre[crs_pkg::PRE_W-1:crs_pkg::PRE_SVC_LO] = '0;
            next_s.wdt = '0;
        end else if (run && wdt_tick && !wdt_dis) begin
            next_s.wdt = s.wdt + crs_pkg::WDT_W'(1);
        end
        // pin low time, saturating past the larger threshold
        if (!pin_low) begin
            next_s.pin_cnt = '0;
        end else if (s.pin_cnt != crs_pkg::CNT_W'(crs_pkg::PIN_MIN_POR)) begin
            next_s.pin_cnt = s.pin_cnt + crs_pkg::CNT_W'(1);
        end
        // read clears, but a flag raised now survives the read
        next_s.cause = (cause_read_in ? 8'h00 : s.cause) | set_bits;
        next_s.seq = s.seq + crs_pkg::CNT_W'(1);
        if (power_up_pulse_in) begin
            // power-on restarts everything and owns the cause register
            next_s = crs_pkg::STATE_RESET;
        end else if (bo_trip && run) begin
            next_s.phase   = crs_pkg::CRS_LONG;
            next_s.seq     = '0;
            next_s.pre     = '0;
            next_s.wdt     = '0;
            next_s.div     = 2'h0;
            next_s.por_src = 1'b1;
        end else if (int_trip) begin
            next_s.phase   = crs_pkg::CRS_DRIVE;
            next_s.seq     = '0;
            next_s.pre     = '0;
            next_s.wdt     = '0;
            next_s.por_src = 1'b0;
            // erased vector forces monitor mode on the way out
            next_s.mon_force = s.mon_force || blk_trip;
        end else begin
            unique case (s.phase)
                crs_pkg::CRS_LONG: begin
                    // pin low and clocks held for the whole timeout
                    if (s.seq == crs_pkg::CNT_W'(crs_pkg::POR_CYCLES - 1)) begin
                        next_s.phase = crs_pkg::CRS_DRIVE;
                        next_s.seq   = '0;
                    end
                end
                crs_pkg::CRS_DRIVE: begin
                    // pin driven so outside chips reset too
                    if (s.seq == crs_pkg::CNT_W'(crs_pkg::DRIVE_CYCLES - 1)) begin
                        next_s.phase = crs_pkg::CRS_HOLD;
                        next_s.seq   = '0;
                    end
                end
                crs_pkg::CRS_HOLD: begin
                    // pin released, internal reset still held
                    if (s.seq == crs_pkg::CNT_W'(crs_pkg::HOLD_CYCLES - 1)) begin
                        next_s.phase = crs_pkg::CRS_RUN;
                        next_s.seq   = '0;
                    end
                end
                crs_pkg::CRS_EXT: begin
                    // outside reset: prescaler keeps running
                    next_s.seq = '0;
                    if (!pin_low) begin
                        next_s.phase = crs_pkg::CRS_RUN;
                    end
                end
                crs_pkg::CRS_RUN: begin
                    next_s.seq = '0;
                    if (pin_low) begin
                        next_s.phase = crs_pkg::CRS_EXT;
                    end else begin
                        // pin back high: later pin resets use short threshold
                        next_s.por_src = 1'b0;
                    end
                end
            endcase
        end
    end

    // single state register, frozen while clock enable is low
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s <= crs_pkg::STATE_RESET;
        end else if (clk_en_in) begin
            s <= next_s;
        end
    end

    // pin is open drain: only ever pulled low
    assign reset_pin_out    = 1'b0;
    assign reset_pin_oe_out = (s.phase == crs_pkg::CRS_LONG)
                           || (s.phase == crs_pkg::CRS_DRIVE);

    // everything else in the chip resets from this
    assign internal_reset_out = !run;

    // clock gating: cpu stops in wait, peripherals keep going
    assign clocks_out.bus_tick  = bus_tick;
    assign clocks_out.periph_en = bus_tick;
    assign clocks_out.cpu_en    = bus_tick && !wait_mode_in;
    assign clocks_out.pll_sel   = pll_select_in;

    // vector pair picked by monitor mode
    assign monitor_force_out = s.mon_force;
    assign reset_vector_out  = (test_in.monitor || s.mon_force)
                             ? crs_pkg::VEC_MON : crs_pkg::VEC_USER;

    assign clock_gen_en_out = s.clk_gen_en;
    assign watchdog_on_out  = !wdt_dis;
    assign reset_cause_out  = s.cause;
    assign prescaler_out    = s.pre;

    // checks; frozen cycles are not judged
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in || !clk_en_in);

    sequence sq_hold_start;
        $rose(s.phase == crs_pkg::CRS_HOLD);
    endsequence

    sequence sq_run_start;
        $rose(s.phase == crs_pkg::CRS_RUN);
    endsequence

    power_on_a: assert property (power_up_pulse_in |=>
        long_ph && s.cause == crs_pkg::CAUSE_POR && clock_gen_en_out)
        else $error("power-on did not restart sequence");

    long_gate_a: assert property (long_ph |->
        reset_pin_oe_out && !clocks_out.periph_en && !clocks_out.bus_tick)
        else $error("clocks or pin wrong while stabilizing");

    drive_len_a: assert property (sq_hold_start |->
        $past(reset_pin_oe_out, 1) && $past(reset_pin_oe_out, 32)
        && !reset_pin_oe_out && internal_reset_out)
        else $error("pin drive length wrong");

    hold_len_a: assert property (sq_run_start |->
        $past(s.phase == crs_pkg::CRS_HOLD, 32) || $past(s.phase == crs_pkg::CRS_EXT))
        else $error("internal reset released early");

    wait_stop_a: assert property (wait_mode_in |-> !clocks_out.cpu_en)
        else $error("cpu clock ran in wait mode");

    bus_rate_a: assert property (clocks_out.bus_tick && !power_up_pulse_in
        && !(bo_trip && run) |=> !clocks_out.bus_tick [*3]
        ##1 (clocks_out.bus_tick || long_ph))
        else $error("bus strobe not one in four");

    read_clear_a: assert property (cause_read_in && set_bits == 8'h00
        && !power_up_pulse_in |=> reset_cause_out == 8'h00)
        else $error("cause read did not clear");

    stop_reset_a: assert property (run && cpu_in.opcode_valid && cpu_in.stop_opcode
        && !power_up_pulse_in && !bo_trip |=>
        s.phase == crs_pkg::CRS_DRIVE && reset_cause_out[crs_pkg::BIT_OPC])
        else $error("stop opcode did not reset");

    data_fetch_a: assert property (run && !int_trip && !bo_trip && !pin_low
        && !power_up_pulse_in |=> run)
        else $error("reset without a source");

    ext_pre_a: assert property (s.phase == crs_pkg::CRS_EXT && !power_up_pulse_in |=>
        s.pre == $past(s.pre) + crs_pkg::PRE_W'(1))
        else $error("pin reset touched prescaler");

    service_a: assert property (run && wdt_service_in && !int_trip && !bo_trip
        && !power_up_pulse_in |=> s.pre[12:4] == 9'h000 && s.wdt == '0)
        else $error("service did not clear counters");

    brownout_a: assert property (bo_trip && run && !power_up_pulse_in |=>
        long_ph && reset_cause_out[crs_pkg::BIT_BO])
        else $error("brown-out did not start long sequence");
endmodule : crs_sequencer

// [crs_far_model.sv]
`timescale 1ns/1ps
// far side of the reset pin: pull-up wire plus an external chip
module crs_far_model (
    input  wire logic pull_low_in,   // external chip asks for a reset
    input  wire logic dev_oe_in,     // device pulling the wire
    input  wire logic dev_data_in,   // device drive value, always low
    output logic      pin_level_out  // resolved wire level
);
    // open drain: any enabled party wins, the pull-up gives high otherwise
    always_comb begin
        pin_level_out = 1'b1;
        if (pull_low_in) begin
            pin_level_out = 1'b0;
        end
        if (dev_oe_in) begin
            pin_level_out = dev_data_in;
        end
    end
endmodule : crs_far_model

// [testbench.sv]
`timescale 1ns/1ps
// self-checking bench for the reset and clock sequencer
module testbench;
    // one table row: cpu activity and the cause it should leave
    typedef struct {
        crs_pkg::crs_cpu_type cpu;
        logic                 rst;
        logic [7:0]           cause;
    } crs_tb_row_type;
    localparam crs_pkg::crs_cpu_type IDLE = '{addr_mapped: 1'b1, default: '0};
    logic                   clk_in, rst_in, clk_en_in, power_up_pulse_in, brownout_in;
    logic                   watchdog_req_in, wdt_service_in, pll_select_in;
    logic                   wait_mode_in, cause_read_in, pull_low, pin_level;
    crs_pkg::crs_cpu_type   cpu_in;
    crs_pkg::crs_test_type  test_in;
    logic                   reset_pin_out, reset_pin_oe_out, internal_reset_out;
    logic                   clock_gen_en_out, monitor_force_out, watchdog_on_out;
    crs_pkg::crs_clk_type   clocks_out;
    logic [15:0]            reset_vector_out;
    logic [7:0]             reset_cause_out;
    logic [12:0]            prescaler_out, pre;
    crs_tb_row_type         rows [6];
    int                     compares = 0;
    int                     miscompares = 0;
    // wire level shared by the device and the outside chip
    crs_far_model far (.pull_low_in(pull_low), .dev_oe_in(reset_pin_oe_out),
        .dev_data_in(reset_pin_out), .pin_level_out(pin_level));
    crs_sequencer DUT (.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
        .power_up_pulse_in(power_up_pulse_in), .brownout_in(brownout_in),
        .watchdog_req_in(watchdog_req_in), .wdt_service_in(wdt_service_in),
        .reset_pin_in(pin_level), .pll_select_in(pll_select_in),
        .wait_mode_in(wait_mode_in), .cause_read_in(cause_read_in), .cpu_in(cpu_in),
        .test_in(test_in), .reset_pin_out(reset_pin_out),
        .reset_pin_oe_out(reset_pin_oe_out), .internal_reset_out(internal_reset_out),
        .clock_gen_en_out(clock_gen_en_out), .clocks_out(clocks_out),
        .reset_vector_out(reset_vector_out), .monitor_force_out(monitor_force_out),
        .watchdog_on_out(watchdog_on_out), .reset_cause_out(reset_cause_out),
        .prescaler_out(prescaler_out));
    // 25 MHz reference
    always #20 clk_in = ~clk_in;
    // verdict, reached from the main sequence or the watchdog
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    // compare helper, four-state safe
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // counts negedges with internal reset high, pin driven, bus strobes while pin driven
    task automatic measure(output int nr, output int no, output int nt);
        nr = 0;
        no = 0;
        nt = 0;
        while (internal_reset_out === 1'b1 && nr < 5000) begin
            nr++;
            if (reset_pin_oe_out === 1'b1) no++;
            if (reset_pin_oe_out === 1'b1 && clocks_out.bus_tick === 1'b1) nt++;
            @(negedge clk_in);
        end
    endtask : measure
    // read the cause register; a read empties it at the next edge
    task automatic clear_cause();
        cause_read_in = 1'b1;
        @(negedge clk_in);
        cause_read_in = 1'b0;
        chk({8'h00, reset_cause_out}, 16'h0000);
    endtask : clear_cause
    // short internal reset: 32 driven, 32 more held
    task automatic fire(input logic [7:0] exp);
        int i, nr, no, nt;
        i = 0;
        while (internal_reset_out !== 1'b1 && i < 8) begin
            @(negedge clk_in);
            i++;
        end
        chk(16'(prescaler_out), 16'h0000);
        chk({8'h00, reset_cause_out}, {8'h00, exp});
        measure(nr, no, nt);
        chk(16'(nr), 16'h0040);
        chk(16'(no), 16'h0020);
        clear_cause();
    endtask : fire
    // hang guard, well past the expected run
    initial begin
        #(40 * 20000);
        miscompares++;
        complete_run();
    end
    // main sequence
    initial begin
        int nr, no, nt, i;
        {clk_in, clk_en_in, rst_in} = 3'h3;
        {power_up_pulse_in, brownout_in, watchdog_req_in, wdt_service_in} = 4'h0;
        {pll_select_in, wait_mode_in, cause_read_in, pull_low} = 4'h0;
        cpu_in = IDLE;
        test_in = '0;
        rows[0] = '{'{opcode_valid: 1'b1, stop_opcode: 1'b1, addr_mapped: 1'b1, default: '0},
            1'b1, 8'h10};
        rows[1] = '{'{opcode_valid: 1'b1, bad_opcode: 1'b1, addr_mapped: 1'b1, default: '0},
            1'b1, 8'h10};
        rows[2] = '{'{opcode_fetch: 1'b1, default: '0}, 1'b1, 8'h08};
        rows[3] = '{'{default: '0}, 1'b0, 8'h00};
        rows[4] = '{'{vector_fetch: 1'b1, vector_byte: 8'h3c, addr_mapped: 1'b1,
            default: '0}, 1'b0, 8'h00};
        rows[5] = '{'{vector_fetch: 1'b1, vector_byte: 8'hff, addr_mapped: 1'b1,
            default: '0}, 1'b1, 8'h04};
        repeat (6) @(negedge clk_in);
        chk({8'h00, reset_cause_out}, 16'h0080);
        chk(16'(clock_gen_en_out), 16'h0001);
        chk(16'(pin_level), 16'h0000);
        rst_in = 1'b0;
        measure(nr, no, nt);
        chk(16'(nr), 16'h1040);
        chk(16'(no), 16'h1020);
        chk(16'(nt), 16'h0008);
        clear_cause();
        // pll source with wait mode: cpu stops, peripherals keep going
        {pll_select_in, wait_mode_in} = 2'h3;
        nr = 0;
        no = 0;
        nt = 0;
        repeat (8) begin
            @(negedge clk_in);
            nr += int'(clocks_out.bus_tick);
            no += int'(clocks_out.cpu_en);
            nt += int'(clocks_out.periph_en);
        end
        chk(16'(nr), 16'h0002);
        chk(16'(no), 16'h0000);
        chk(16'(nt), 16'h0002);
        chk(16'(clocks_out.pll_sel), 16'h0001);
        wait_mode_in = 1'b0;
        chk(reset_vector_out, 16'hfffe);
        test_in.monitor = 1'b1;
        @(negedge clk_in);
        chk(reset_vector_out, 16'hfefe);
        test_in.monitor = 1'b0;
        wdt_service_in = 1'b1;
        @(negedge clk_in);
        wdt_service_in = 1'b0;
        chk(16'(prescaler_out[12:4]), 16'h0000);
        // table of cpu-side sources, harmless cases among them
        for (int r = 0; r < 6; r++) begin
            cpu_in = rows[r].cpu;
            @(negedge clk_in);
            cpu_in = IDLE;
            if (rows[r].rst) begin
                fire(rows[r].cause);
            end else begin
                repeat (4) @(negedge clk_in);
                chk(16'(internal_reset_out), 16'h0000);
            end
        end
        chk(16'(monitor_force_out), 16'h0001);
        chk(reset_vector_out, 16'hfefe);
        // watchdog request while disabled by test voltage, then enabled
        test_in = '{monitor: 1'b1, hv_reset: 1'b1, default: '0};
        watchdog_req_in = 1'b1;
        repeat (6) @(negedge clk_in);
        chk(16'(watchdog_on_out), 16'h0000);
        chk(16'(internal_reset_out), 16'h0000);
        test_in = '{break_st: 1'b1, hv_reset: 1'b1, default: '0};
        @(negedge clk_in);
        chk(16'(watchdog_on_out), 16'h0000);
        test_in = '{monitor: 1'b1, hv_irq: 1'b1, default: '0};
        @(negedge clk_in);
        chk(16'(internal_reset_out), 16'h0000);
        test_in = '0;
        i = 0;
        while (internal_reset_out !== 1'b1 && i < 8) begin
            @(negedge clk_in);
            i++;
        end
        watchdog_req_in = 1'b0;
        fire(8'h20);
        // short pin pulse leaves no flag; a long one does, counter runs on
        pull_low = 1'b1;
        repeat (20) @(negedge clk_in);
        pull_low = 1'b0;
        repeat (6) @(negedge clk_in);
        chk({8'h00, reset_cause_out}, 16'h0000);
        pre = prescaler_out;
        pull_low = 1'b1;
        repeat (80) @(negedge clk_in);
        chk(16'(internal_reset_out), 16'h0001);
        chk(16'(prescaler_out - pre), 16'h0050);
        chk({8'h00, reset_cause_out}, 16'h0040);
        pull_low = 1'b0;
        repeat (6) @(negedge clk_in);
        chk(16'(internal_reset_out), 16'h0000);
        clear_cause();
        // brief low supply is ignored, a lasting one starts the long sequence
        brownout_in = 1'b1;
        repeat (20) @(negedge clk_in);
        brownout_in = 1'b0;
        repeat (4) @(negedge clk_in);
        chk(16'(internal_reset_out), 16'h0000);
        brownout_in = 1'b1;
        i = 0;
        while (internal_reset_out !== 1'b1 && i < 60) begin
            @(negedge clk_in);
            i++;
        end
        brownout_in = 1'b0;
        chk({8'h00, reset_cause_out}, 16'h0002);
        measure(nr, no, nt);
        chk(16'(nr - no), 16'h0020);
        chk(16'(nt), 16'h0008);
        // power-on pulse in mid-run restarts the long sequence
        power_up_pulse_in = 1'b1;
        @(negedge clk_in);
        power_up_pulse_in = 1'b0;
        chk({8'h00, reset_cause_out}, 16'h0080);
        chk(16'(monitor_force_out), 16'h0000);
        chk(16'(prescaler_out), 16'h0000);
        measure(nr, no, nt);
        chk(16'(nr), 16'h1040);
        complete_run();
    end
endmodule : testbench
